// ---- hdl/frm_motor_decode.v ----
/*
  Motor enable decoder: turns the drive output register motor nibble
  into the two active-low motor enables, direct or four-drive encoded.
  Assumes registered inputs on the same clock; output is combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module frm_motor_decode (
  // Controls
  input wire four_drive,
  input wire [1:0] drive_sel,
  input wire [3:0] motor_bits,
  // Result, active low
  output reg [1:0] next_motor_n
);
  always @* begin
    if (four_drive) begin
      // Encoded: the selected drive's motor bit puts its number on the pair
      if (motor_bits[drive_sel]) begin
        next_motor_n = ~drive_sel;
      end else begin
        next_motor_n = 2'h3;
      end
    end else begin
      // Direct: drive_sel has no say here
      next_motor_n = ~motor_bits[1:0];
    end
  end
endmodule // frm_motor_decode
`default_nettype wire

// ---- hdl/frm_top.v ----
/*
  Floppy reset and drive-side pin control: reset of controller registers
  and command parameters, motor enable and head side outputs, media sense
  gating. Assumes a register master on clk and drive pins asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "frm_defines.vh"
module frm_top (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Drive pins
  input wire [1:0] media_type_in,
  output reg [1:0] motor_enable_n,
  output reg head_side_n,
  // Sequencing status
  output reg seq_busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;

  reg [7:0] drive_output_reg;
  reg [7:0] data_rate_reg;
  reg [7:0] config_control_reg;
  reg [7:0] floppy_config;
  reg [7:0] option_param;
  reg [7:0] fifo_setup_cmd;
  reg [7:0] param_hold;
  reg [7:0] drive_timing;
  reg head_side_sel;
  reg [1:0] state;
  reg [1:0] media_meta;
  reg [1:0] media_sync;
  reg [1:0] media_sense;
  wire [1:0] next_motor_n;

  frm_motor_decode u_dec (
    .four_drive(floppy_config[`FRM_CFG_FOUR_DRIVE]),
    .drive_sel(drive_output_reg[`FRM_DRIVE_SEL_LO+1:`FRM_DRIVE_SEL_LO]),
    .motor_bits(drive_output_reg[`FRM_MOTOR_LO+3:`FRM_MOTOR_LO]),
    .next_motor_n(next_motor_n)
  );

  // Register file; reset wins over any write in the same cycle
  always @(posedge clk) begin
    if (rst) begin
      drive_output_reg <= `FRM_RST_ZERO;
      data_rate_reg <= `FRM_RST_ZERO;
      config_control_reg <= `FRM_RST_ZERO;
      floppy_config <= `FRM_RST_FLOPPY_CONFIG;
      option_param <= `FRM_RST_OPTION_PARAM;
      fifo_setup_cmd <= `FRM_RST_FIFO_SETUP;
      param_hold <= `FRM_RST_PARAM_HOLD;
      head_side_sel <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `FRM_ADDR_DRIVE_OUTPUT: drive_output_reg <= reg_wdata;
        `FRM_ADDR_DATA_RATE: data_rate_reg <= reg_wdata;
        `FRM_ADDR_CONFIG_CONTROL: config_control_reg <= reg_wdata;
        `FRM_ADDR_FLOPPY_CONFIG: floppy_config <= reg_wdata;
        `FRM_ADDR_OPTION_PARAM: option_param <= reg_wdata;
        `FRM_ADDR_FIFO_SETUP: fifo_setup_cmd <= reg_wdata;
        `FRM_ADDR_PARAM_HOLD: param_hold <= reg_wdata;
        `FRM_ADDR_HEAD_CTRL: head_side_sel <= reg_wdata[0];
        default: begin
        end
      endcase
    end
  end

  // Timing parameters are loaded only by software, so reset leaves them
  always @(posedge clk) begin
    if (reg_wr && reg_addr == `FRM_ADDR_DRIVE_TIMING) begin
      drive_timing <= reg_wdata;
    end
  end

  // Sequencer: runs while any motor is requested
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      seq_busy <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (drive_output_reg[7:4] != 4'h0) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (drive_output_reg[7:4] == 4'h0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      seq_busy <= (state == ST_RUN);
    end
  end

  // Drive outputs
  always @(posedge clk) begin
    if (rst) begin
      motor_enable_n <= 2'h3;
      head_side_n <= 1'b1;
    end else begin
      motor_enable_n <= next_motor_n;
      head_side_n <= ~head_side_sel;
    end
  end

  // Media inputs cross from the pins through two flops
  always @(posedge clk) begin
    if (rst) begin
      media_meta <= 2'h0;
      media_sync <= 2'h0;
      media_sense <= 2'h0;
    end else begin
      media_meta <= media_type_in;
      media_sync <= media_meta;
      if (floppy_config[`FRM_CFG_MEDIA_SENSE]) begin
        media_sense <= media_sync;
      end else begin
        media_sense <= 2'h0;
      end
    end
  end

  // Read port; unmapped addresses read zero
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `FRM_ADDR_DRIVE_OUTPUT: reg_rdata <= drive_output_reg;
        `FRM_ADDR_DATA_RATE: reg_rdata <= data_rate_reg;
        `FRM_ADDR_CONFIG_CONTROL: reg_rdata <= config_control_reg;
        `FRM_ADDR_FLOPPY_CONFIG: reg_rdata <= floppy_config;
        `FRM_ADDR_OPTION_PARAM: reg_rdata <= option_param;
        `FRM_ADDR_FIFO_SETUP: reg_rdata <= fifo_setup_cmd;
        `FRM_ADDR_PARAM_HOLD: reg_rdata <= param_hold;
        `FRM_ADDR_DRIVE_TIMING: reg_rdata <= drive_timing;
        `FRM_ADDR_HEAD_CTRL: reg_rdata <= {7'h00, head_side_sel};
        `FRM_ADDR_STATUS: reg_rdata <= {3'h0, seq_busy, media_sense,
                                        motor_enable_n};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // frm_top
`default_nettype wire

// ---- pkg/frm_defines.vh ----
/*
  Constants for the floppy reset and motor pin block: register offsets,
  field positions, reset values and defaults.
  Assumes inclusion by bare name from the design files.
*/
`ifndef FRM_DEFINES_VH
`define FRM_DEFINES_VH

// Register offsets on the plain register port
`define FRM_ADDR_DRIVE_OUTPUT 8'h02
`define FRM_ADDR_DATA_RATE 8'h04
`define FRM_ADDR_CONFIG_CONTROL 8'h07
`define FRM_ADDR_HEAD_CTRL 8'h10
`define FRM_ADDR_OPTION_PARAM 8'h11
`define FRM_ADDR_FIFO_SETUP 8'h12
`define FRM_ADDR_PARAM_HOLD 8'h13
`define FRM_ADDR_DRIVE_TIMING 8'h14
`define FRM_ADDR_STATUS 8'h15
`define FRM_ADDR_FLOPPY_CONFIG 8'hF0

// Field positions
`define FRM_CFG_FOUR_DRIVE 7
`define FRM_CFG_MEDIA_SENSE 6
`define FRM_DRIVE_SEL_LO 0
`define FRM_MOTOR_LO 4

// Reset values
`define FRM_RST_ZERO 8'h00
`define FRM_RST_FLOPPY_CONFIG 8'h00
`define FRM_RST_OPTION_PARAM 8'h00
`define FRM_RST_FIFO_SETUP 8'h00
`define FRM_RST_PARAM_HOLD 8'h00
`define FRM_RST_DRIVE_TIMING 8'h00

`endif

// ---- tb/frm_checker.sv ----
/* Checker on frm_top ports. Assumes the bind below. */
`timescale 1ns/1ns
`default_nettype none
module frm_checker (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] motor_enable_n,
  input wire logic head_side_n,
  input wire logic seq_busy
);
  logic [7:0] drv_out, cfg;
  logic side;
  wire [1:0] en = cfg[7] ?
    (drv_out[4+drv_out[1:0]] ? ~drv_out[1:0] : 2'b11) : ~drv_out[5:4];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk) begin
    if (rst) begin
      drv_out <= 8'h00;
      cfg <= 8'h00;
      side <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h02) drv_out <= reg_wdata;
      if (reg_addr == 8'hF0) cfg <= reg_wdata;
      if (reg_addr == 8'h10) side <= reg_wdata[0];
    end
  end
  reset_pins_a:
  assert property (disable iff (1'b0) rst |=> &motor_enable_n && head_side_n)
    else $error("pins active in reset");
  reset_busy_a:
  assert property (disable iff (1'b0) rst |=> !seq_busy) else $error("busy");
  reset_rdata_a:
  assert property (disable iff (1'b0) rst |=> reg_rdata == 8'h00)
    else $error("rdata in reset");
  drive_out_read_a:
  assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata == drv_out)
    else $error("drive output read");
  config_read_a:
  assert property (reg_rd && reg_addr == 8'hF0 |=> reg_rdata == cfg)
    else $error("cfg read");
  motor_pins_a:
  assert property (1'b1 |=> motor_enable_n == $past(en)) else $error("motor");
  head_side_a:
  assert property (1'b1 |=> head_side_n == !$past(side)) else $error("head");
  media_gate_a:
  assert property (reg_rd && reg_addr == 8'h15 && !cfg[6] && !$past(cfg[6], 4)
    |=> reg_rdata[3:2] == 2'b00) else $error("media");
endmodule // frm_checker
bind frm_top frm_checker chk (.*);
`default_nettype wire

// ---- tb/frm_drive_model.sv ----
/* Drive cable model. Assumes pull-ups on the sense lines. */
`timescale 1ns/1ns
`default_nettype none
module frm_drive_model (
  // Drive side
  input wire logic [1:0] motor_enable_n,
  input wire logic [1:0] sense,
  output logic [1:0] media_type_in
);
  // No drive selected: lines float up
  assign media_type_in = &motor_enable_n ? 2'b11 : sense;
endmodule // frm_drive_model
`default_nettype wire

// ---- tb/test_floppy_reset_and_motor_pins.sv ----
/* Bench for frm_top. Assumes 20 MHz clk and the drive model. */
`timescale 1ns/1ns
`default_nettype none
module test_floppy_reset_and_motor_pins;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
  logic [1:0] sense = 2'b01;
  wire [7:0] reg_rdata;
  wire [1:0] media_type_in, motor_enable_n;
  wire head_side_n, seq_busy;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  frm_top uut (.*);
  frm_drive_model drv (.*);
  always #25 clk = ~clk;
  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand in the cycle after the strobe; take them at its end
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic pins(input logic [1:0] m, input logic h);
    repeat (2) @(posedge clk);
    chk("pins", {5'h00, h, m}, {5'h00, head_side_n, motor_enable_n});
  endtask
  task automatic t_motor(input logic f);
    logic [3:0] n;
    logic [1:0] s;
    wr(8'hF0, {f, 7'h00});
    for (int i = 0; i < 64; i++) begin
      n = i[5:2];
      s = i[1:0];
      wr(8'h02, {n, 2'b00, s});
      pins(f ? (n[s] ? ~s : 2'b11) : ~n[1:0], 1'b1);
    end
  endtask
  task automatic t_head;
    // Clear the motor nibble left by the four-drive sweep
    wr(8'h02, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(8'h10, {7'h00, b[0]});
      pins(2'b11, !b[0]);
    end
  endtask
  task automatic t_media;
    wr(8'h02, 8'h10);
    for (int b = 0; b < 2; b++) begin
      wr(8'hF0, {1'b0, b[0], 6'h00});
      repeat (5) @(posedge clk);
      rd(8'h15);
      chk("media", {6'h00, b[0] ? sense : 2'b00}, {6'h00, d[3:2]});
    end
  endtask
  task automatic t_reset;
    logic [7:0] a [7] = '{8'h02, 8'h04, 8'h07, 8'h11, 8'h12, 8'h13, 8'hF0};
    foreach (a[i]) wr(a[i], 8'hA5);
    wr(8'h14, 8'h5A);
    chk("busy", 8'h01, {7'h00, seq_busy});
    rst <= 1'b1;
    pins(2'b11, 1'b1);
    chk("busy", 8'h00, {7'h00, seq_busy});
    rst <= 1'b0;
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset reg", 8'h00, d);
    end
    rd(8'h14);
    chk("timing", 8'h5A, d);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_motor(1'b0);
    t_motor(1'b1);
    t_head;
    t_media;
    t_reset;
    test_done;
  end
endmodule // test_floppy_reset_and_motor_pins
`default_nettype wire
